// ---- src/hsrp_pkg.sv ----
// constants and types shared by the serial host register port
package hsrp_pkg;
  // ***************************************************
  // widths
  // ***************************************************
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int PAGE_W = 2;
  // ***************************************************
  // link rates
  // ***************************************************
  localparam int SPI_MAX_RATE_MBPS = 40;
  localparam int I2C_STD_RATE_KBPS = 100;
  localparam int I2C_FAST_RATE_KBPS = 400;
  localparam int SYS_CLK_MHZ = 50;
  // ***************************************************
  // map and field layout
  // ***************************************************
  localparam logic [6:0] PAGE_SEL_ADDR = 7'h7F;
  localparam logic [1:0] PAGE_RST = 2'h0;
  localparam int SPI_RW_BIT = 7;
  localparam int I2C_AINC_BIT = 7;
  localparam int I2C_RW_BIT = 0;
  localparam logic [4:0] I2C_ADDR_HI_DEF = 5'h10;
  // ***************************************************
  // byte framing counts
  // ***************************************************
  localparam logic [2:0] SPI_LAST_BIT = 3'h7;
  localparam logic [3:0] I2C_BYTE_BITS = 4'h8;
  localparam logic [3:0] I2C_LAST_TX = 4'h7;
  localparam logic [1:0] SPI_IDX_CMD = 2'h0;
  localparam logic [1:0] SPI_IDX_DUMMY = 2'h1;
  localparam logic [1:0] SPI_IDX_DATA = 2'h2;
  // ***************************************************
  // two-wire target states
  // ***************************************************
  typedef enum logic [6:0] {
    I2C_IDLE = 7'h01,
    I2C_ADDR = 7'h02,
    I2C_REGADR = 7'h04,
    I2C_WDATA = 7'h08,
    I2C_ACK = 7'h10,
    I2C_RDATA = 7'h20,
    I2C_RACK = 7'h40
  } hsrp_i2c_st_t;
endpackage

// ---- src/hsrp_sync.sv ----
// two flip-flop level synchroniser
`timescale 1ns/1ps
module hsrp_sync #(
  parameter int WIDTH = 1
) (
  // clock
  input wire logic clock,
  // level in and out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  // ***************************************************
  // two stages, first read only by second
  // ***************************************************
  always_ff @(posedge clock) begin
    meta_r <= d;
    q <= meta_r;
  end
endmodule

// ---- src/hsrp_port.sv ----
// serial host register port: four-wire or two-wire target into a paged register map
// Operation
// [R1] strap low selects the four-wire serial slave with register writes and reads
// [R2] four-wire link handles bit rates up to 40 Mbps
// [R3] chip select high: input ignored, serial output released
// [R4] input sampled on rising host clock, output shifted on falling edge
// [R5] first byte: top bit direction, lower seven bits register address
// [R6] second byte is ignored, data starts with the third byte
// [R7] address increments after every data byte while select stays low
// [R8] strap high selects the two-wire bus target
// [R9] two-wire side is a target only, standard and fast rates
// [R10] clock pin is bus clock, output pin bus data, select and input are address bits
// [R11] target answers seven-bit address: five fixed bits plus two strap bits
// [R12] register address byte follows the target address, seven bits plus increment flag
// [R13] with increment on, address advances by one per data byte
// [R14] read without register byte uses the retained address
// [R15] random reads work with increment on or off
// [R16] page register at top address of every page picks the page
// [R17] increment flag is the top bit of the register address byte
// [R18] host writes register byte, repeated start, then reads
`timescale 1ns/1ps
module hsrp_port
  import hsrp_pkg::*;
#(
  parameter logic [4:0] I2C_ADDR_HI = I2C_ADDR_HI_DEF
) (
  // system
  input wire logic clock,
  input wire logic sys_rst,
  // host pins
  input wire logic host_port_select,
  input wire logic host_serial_clock,
  input wire logic host_chip_select_n,
  input wire logic host_serial_in,
  input wire logic host_serial_out_in,
  output logic host_serial_out,
  output logic host_serial_out_oe,
  // register map side
  output logic spi_mode,
  output logic [PAGE_W+ADDR_W-1:0] reg_addr,
  output logic [DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata
);
  // ***************************************************
  // system domain pin synchronisers
  // ***************************************************
  logic [4:0] pin_s;
  logic sel_s, a0_s, a1_s, scl_s, sda_s;
  hsrp_sync #(.WIDTH(5)) u_pin_sync (
    .clock(clock),
    .d({host_port_select, host_chip_select_n, host_serial_in, host_serial_clock, host_serial_out_in}),
    .q(pin_s)
  );
  assign sel_s = pin_s[4];
  assign a0_s = pin_s[3];
  assign a1_s = pin_s[2];
  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];

  logic spi_mode_r;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      spi_mode_r <= ~sel_s; // [R1] [R8]
    end
  end
  assign spi_mode = spi_mode_r;

  // ***************************************************
  // link domain: four-wire frame
  // ***************************************************
  logic mode_l;
  logic ack_l;
  logic [2:0] sp_bit_r;
  logic [1:0] sp_idx_r;
  logic [6:0] sp_sh_r;
  logic sp_rw_r;
  logic [6:0] sp_ptr_r;
  logic [7:0] sp_byte;
  logic sp_go;
  logic sp_rd_go;
  logic sp_wr_go;
  hsrp_sync #(.WIDTH(1)) u_mode_sync (.clock(host_serial_clock), .d(spi_mode_r), .q(mode_l));

  assign sp_byte = {sp_sh_r, host_serial_in};
  assign sp_go = ~host_chip_select_n & mode_l & (sp_bit_r == SPI_LAST_BIT);
  assign sp_rd_go = sp_go & (sp_idx_r == SPI_IDX_CMD ? sp_byte[SPI_RW_BIT] : sp_rw_r);
  assign sp_wr_go = sp_go & (sp_idx_r == SPI_IDX_DATA) & ~sp_rw_r;

  always_ff @(posedge host_serial_clock or posedge host_chip_select_n) begin // [R2]
    if (host_chip_select_n) begin // [R3]
      sp_bit_r <= 3'h0;
      sp_idx_r <= SPI_IDX_CMD;
      sp_sh_r <= 7'h00;
      sp_rw_r <= 1'b0;
      sp_ptr_r <= 7'h00;
    end else begin
      sp_sh_r <= sp_byte[6:0]; // [R4]
      sp_bit_r <= sp_bit_r + 3'h1;
      if (sp_bit_r == SPI_LAST_BIT) begin
        if (sp_idx_r == SPI_IDX_CMD) begin
          sp_rw_r <= sp_byte[SPI_RW_BIT]; // [R5]
          sp_ptr_r <= sp_byte[SPI_RW_BIT] ? sp_byte[6:0] + 7'h01 : sp_byte[6:0];
          sp_idx_r <= SPI_IDX_DUMMY;
        end else if (sp_idx_r == SPI_IDX_DUMMY) begin
          sp_idx_r <= SPI_IDX_DATA; // [R6]
          if (sp_rw_r) begin
            sp_ptr_r <= sp_ptr_r + 7'h01;
          end
        end else begin
          sp_ptr_r <= sp_ptr_r + 7'h01; // [R7]
        end
      end
    end
  end

  // requests toward the system domain, toggles with held words
  logic sp_wr_tgl_r, sp_rd_tgl_r;
  logic [6:0] sp_wr_a_r, sp_rd_a_r;
  logic [7:0] sp_wr_d_r;
  always_ff @(posedge host_serial_clock or posedge sys_rst) begin
    if (sys_rst) begin
      sp_wr_tgl_r <= 1'b0;
      sp_rd_tgl_r <= 1'b0;
      sp_wr_a_r <= 7'h00;
      sp_rd_a_r <= 7'h00;
      sp_wr_d_r <= 8'h00;
    end else begin
      if (sp_wr_go) begin
        sp_wr_tgl_r <= ~sp_wr_tgl_r; // [R7]
        sp_wr_a_r <= sp_ptr_r;
        sp_wr_d_r <= sp_byte;
      end
      if (sp_rd_go) begin
        sp_rd_tgl_r <= ~sp_rd_tgl_r; // [R7]
        sp_rd_a_r <= sp_idx_r == SPI_IDX_CMD ? sp_byte[6:0] : sp_ptr_r;
      end
    end
  end

  // read data returning from the system domain
  logic ack_tgl_r;
  logic [7:0] rdata_r;
  logic ack_d_l_r;
  logic [7:0] sp_rdbuf_r;
  hsrp_sync #(.WIDTH(1)) u_ack_sync (.clock(host_serial_clock), .d(ack_tgl_r), .q(ack_l));
  always_ff @(posedge host_serial_clock or posedge sys_rst) begin
    if (sys_rst) begin
      ack_d_l_r <= 1'b0;
      sp_rdbuf_r <= 8'h00;
    end else begin
      ack_d_l_r <= ack_l;
      if (ack_l != ack_d_l_r) begin
        sp_rdbuf_r <= rdata_r;
      end
    end
  end

  // serial output on the falling edge
  logic sp_dout_r, sp_oe_r;
  logic [7:0] sp_tx_r;
  always_ff @(negedge host_serial_clock or posedge host_chip_select_n) begin
    if (host_chip_select_n) begin
      sp_dout_r <= 1'b0; // [R3]
      sp_oe_r <= 1'b0;
      sp_tx_r <= 8'h00;
    end else begin
      sp_oe_r <= mode_l;
      if (sp_bit_r == 3'h0 && sp_idx_r == SPI_IDX_DATA && sp_rw_r) begin
        sp_dout_r <= mode_l & sp_rdbuf_r[7]; // [R4]
        sp_tx_r <= {sp_rdbuf_r[6:0], 1'b0};
      end else begin
        sp_dout_r <= mode_l & sp_tx_r[7];
        sp_tx_r <= {sp_tx_r[6:0], 1'b0};
      end
    end
  end

  // ***************************************************
  // system domain: four-wire request intake
  // ***************************************************
  logic [1:0] sp_tgl_s;
  logic sp_wr_d_r_s, sp_rd_d_r_s;
  logic spi_wr_evt, spi_rd_evt;
  hsrp_sync #(.WIDTH(2)) u_req_sync (.clock(clock), .d({sp_wr_tgl_r, sp_rd_tgl_r}), .q(sp_tgl_s));
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sp_wr_d_r_s <= 1'b0;
      sp_rd_d_r_s <= 1'b0;
    end else begin
      sp_wr_d_r_s <= sp_tgl_s[1];
      sp_rd_d_r_s <= sp_tgl_s[0];
    end
  end
  assign spi_wr_evt = spi_mode_r & (sp_tgl_s[1] ^ sp_wr_d_r_s);
  assign spi_rd_evt = spi_mode_r & (sp_tgl_s[0] ^ sp_rd_d_r_s);

  // ***************************************************
  // system domain: two-wire target
  // ***************************************************
  hsrp_i2c_st_t st_r, nxt_r;
  logic scl_d_r, sda_d_r;
  logic [3:0] ib_r;
  logic [7:0] ish_r, itx_r;
  logic [6:0] iptr_r;
  logic iainc_r, sda_oe_r;
  logic i2c_on, i_start, i_stop, i_rise, i_fall, i_done, i_match;
  logic i2c_wr_go, i2c_rd_go, i_mack;
  logic [6:0] i2c_rd_a;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s; // [R10]
      sda_d_r <= sda_s;
    end
  end
  assign i2c_on = ~spi_mode_r;
  assign i_start = i2c_on & scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign i_stop = i2c_on & scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign i_rise = i2c_on & scl_s & ~scl_d_r;
  assign i_fall = i2c_on & ~scl_s & scl_d_r;
  assign i_done = i_fall & (ib_r == I2C_BYTE_BITS);
  assign i_match = ish_r[7:1] == {I2C_ADDR_HI, a1_s, a0_s}; // [R10] [R11]
  assign i_mack = (st_r == I2C_RACK) & i_rise & ~sda_s;
  assign i2c_wr_go = ~i_start & ~i_stop & (st_r == I2C_WDATA) & i_done;
  assign i2c_rd_go = ~i_start & ~i_stop & (((st_r == I2C_ADDR) & i_done & i_match & ish_r[I2C_RW_BIT]) | i_mack);
  assign i2c_rd_a = (i_mack & iainc_r) ? iptr_r + 7'h01 : iptr_r; // [R14] [R15]

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r <= I2C_IDLE;
      nxt_r <= I2C_IDLE;
      ib_r <= 4'h0;
      ish_r <= 8'h00;
      itx_r <= 8'h00;
      iptr_r <= 7'h00;
      iainc_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (i_start) begin
      st_r <= I2C_ADDR; // [R18]
      ib_r <= 4'h0;
      sda_oe_r <= 1'b0;
    end else if (i_stop) begin
      st_r <= I2C_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      case (st_r)
        I2C_ADDR, I2C_REGADR, I2C_WDATA: begin
          if (i_rise) begin
            ish_r <= {ish_r[6:0], sda_s};
            ib_r <= ib_r + 4'h1;
          end else if (i_done) begin
            ib_r <= 4'h0;
            sda_oe_r <= 1'b1;
            st_r <= I2C_ACK;
            if (st_r == I2C_ADDR) begin
              nxt_r <= ish_r[I2C_RW_BIT] ? I2C_RDATA : I2C_REGADR; // [R14]
              if (!i_match) begin
                sda_oe_r <= 1'b0; // [R11]
                st_r <= I2C_IDLE;
              end
            end else if (st_r == I2C_REGADR) begin
              iptr_r <= ish_r[6:0]; // [R12]
              iainc_r <= ish_r[I2C_AINC_BIT]; // [R17]
              nxt_r <= I2C_WDATA;
            end else begin
              nxt_r <= I2C_WDATA;
              if (iainc_r) begin
                iptr_r <= iptr_r + 7'h01; // [R13]
              end
            end
          end
        end
        I2C_ACK: begin
          if (i_fall) begin
            st_r <= nxt_r;
            ib_r <= 4'h0;
            if (nxt_r == I2C_RDATA) begin
              itx_r <= rdata_r;
              sda_oe_r <= ~rdata_r[7];
            end else begin
              sda_oe_r <= 1'b0;
            end
          end
        end
        I2C_RDATA: begin
          if (i_fall) begin
            ib_r <= ib_r + 4'h1;
            itx_r <= {itx_r[6:0], 1'b0};
            if (ib_r == I2C_LAST_TX) begin
              sda_oe_r <= 1'b0;
              st_r <= I2C_RACK;
            end else begin
              sda_oe_r <= ~itx_r[6];
            end
          end
        end
        I2C_RACK: begin
          if (i_rise) begin
            if (sda_s) begin
              st_r <= I2C_IDLE;
            end else begin
              st_r <= I2C_ACK;
              nxt_r <= I2C_RDATA;
              iptr_r <= i2c_rd_a; // [R13] [R15]
            end
          end
        end
        default: begin
          st_r <= I2C_IDLE;
        end
      endcase
    end
  end

  // ***************************************************
  // register map access and page select
  // ***************************************************
  logic wr_go, rd_go;
  logic [6:0] wr_a, rd_a;
  logic [7:0] wr_d;
  logic [PAGE_W-1:0] page_r;
  logic [PAGE_W+ADDR_W-1:0] reg_addr_r;
  logic [7:0] reg_wdata_r;
  logic reg_wr_r, reg_rd_r, rd_page_r;
  assign wr_go = spi_wr_evt | i2c_wr_go;
  assign rd_go = spi_rd_evt | i2c_rd_go;
  assign wr_a = spi_mode_r ? sp_wr_a_r : iptr_r;
  assign wr_d = spi_mode_r ? sp_wr_d_r : ish_r;
  assign rd_a = spi_mode_r ? sp_rd_a_r : i2c_rd_a;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      page_r <= PAGE_RST;
      reg_addr_r <= '0;
      reg_wdata_r <= 8'h00;
      reg_wr_r <= 1'b0;
      reg_rd_r <= 1'b0;
      rd_page_r <= 1'b0;
    end else begin
      reg_wr_r <= 1'b0;
      reg_rd_r <= 1'b0;
      if (wr_go) begin
        reg_addr_r <= {page_r, wr_a};
        reg_wdata_r <= wr_d;
        if (wr_a == PAGE_SEL_ADDR) begin
          page_r <= wr_d[PAGE_W-1:0]; // [R16]
        end else begin
          reg_wr_r <= 1'b1;
        end
      end else if (rd_go) begin
        reg_addr_r <= {page_r, rd_a};
        rd_page_r <= rd_a == PAGE_SEL_ADDR; // [R16]
        reg_rd_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdata_r <= 8'h00;
      ack_tgl_r <= 1'b0;
    end else if (reg_rd_r) begin
      rdata_r <= rd_page_r ? {{(DATA_W-PAGE_W){1'b0}}, page_r} : reg_rdata;
      if (spi_mode_r) begin
        ack_tgl_r <= ~ack_tgl_r;
      end
    end
  end

  assign reg_addr = reg_addr_r;
  assign reg_wdata = reg_wdata_r;
  assign reg_wr = reg_wr_r;
  assign reg_rd = reg_rd_r;
  // link-side mode copy lags a strap change until the host clock runs
  assign host_serial_out = sp_dout_r & spi_mode_r; // [R10]
  assign host_serial_out_oe = (sp_oe_r & spi_mode_r) | sda_oe_r; // [R3] [R10]

  // ***************************************************
  // checks
  // ***************************************************
  strap_hold_a: assert property (@(posedge clock) disable iff (sys_rst) $stable(spi_mode_r)) // [R1] [R8]
    else $error("mode strap changed outside reset");
  target_only_a: assert property (@(posedge clock) disable iff (sys_rst) sda_oe_r |-> !spi_mode_r) // [R9]
    else $error("bus data driven in four-wire mode");
  spi_write_a: assert property (@(posedge clock) disable iff (sys_rst) // [R7]
    spi_wr_evt && sp_wr_a_r != PAGE_SEL_ADDR |=> reg_wr_r && reg_addr_r[6:0] == $past(sp_wr_a_r))
    else $error("four-wire write not issued");
  page_sel_a: assert property (@(posedge clock) disable iff (sys_rst) // [R16]
    wr_go && wr_a == PAGE_SEL_ADDR |=> !reg_wr_r && page_r == $past(wr_d[PAGE_W-1:0]))
    else $error("page select write mishandled");
  addr_ack_a: assert property (@(posedge clock) disable iff (sys_rst) // [R11]
    st_r == I2C_ADDR && i_done && !i_start && !i_stop |=> sda_oe_r == $past(i_match))
    else $error("target address answer wrong");
  reg_byte_a: assert property (@(posedge clock) disable iff (sys_rst) // [R12] [R17]
    st_r == I2C_REGADR && i_done && !i_start && !i_stop |=> iptr_r == $past(ish_r[6:0]) && iainc_r == $past(ish_r[7]))
    else $error("register address byte not taken");
  auto_inc_a: assert property (@(posedge clock) disable iff (sys_rst) // [R13]
    i2c_wr_go |=> iptr_r == ($past(iainc_r) ? $past(iptr_r) + 7'h01 : $past(iptr_r)))
    else $error("write address step wrong");
  cur_read_a: assert property (@(posedge clock) disable iff (sys_rst) // [R14]
    st_r == I2C_ADDR && i2c_rd_go |=> reg_rd_r && reg_addr_r[6:0] == $past(iptr_r) ##1 !reg_rd_r)
    else $error("current address read wrong");
  spi_hiz_a: assert property (@(posedge host_serial_clock) disable iff (sys_rst) // [R3]
    host_chip_select_n |-> !sp_oe_r && !sp_dout_r)
    else $error("serial output driven while deselected");
  spi_cmd_a: assert property (@(posedge host_serial_clock) disable iff (sys_rst) // [R5]
    !host_chip_select_n && sp_idx_r == SPI_IDX_CMD && sp_bit_r == SPI_LAST_BIT
    |=> sp_rw_r == $past(sp_byte[7]) && sp_idx_r == SPI_IDX_DUMMY)
    else $error("command byte decoded wrong");
endmodule

// ---- bench/hsrp_host_model.sv ----
// host master model driving the four-wire and two-wire host pins
`timescale 1ns/1ps
module hsrp_host_model (
  // host pins
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  output logic sda_low,
  // resolved data pin and mode
  input wire logic pin,
  input wire logic i2c
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    sda_low = 1'b0;
  end
  // unselected input line keeps changing
  always begin
    #7;
    if (!i2c && cs_n) mosi = ~mosi;
  end
  // *****
  // four-wire frames
  // *****
  task automatic spi_begin();
    cs_n = 1'b0;
    #10;
  endtask
  task automatic spi_end();
    #5;
    cs_n = 1'b1;
    #20;
  endtask
  // clock idles low, data set while low, read at rising edge
  task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #3;
      sclk = 1'b1;
      rx[i] = pin;
      #3;
      sclk = 1'b0;
    end
    #320;
  endtask
  task automatic spi_noise();
    for (int i = 0; i < 8; i++) begin
      #3;
      sclk = 1'b1;
      #3;
      sclk = 1'b0;
    end
  endtask
  // *****
  // two-wire bus
  // *****
  task automatic i2c_idle(input logic [1:0] strap);
    cs_n = strap[0];
    mosi = strap[1];
    sclk = 1'b1;
    sda_low = 1'b0;
  endtask
  task automatic i2c_start();
    sda_low = 1'b0;
    #625;
    sclk = 1'b1;
    #625;
    sda_low = 1'b1;
    #625;
    sclk = 1'b0;
    #625;
  endtask
  task automatic i2c_stop();
    sda_low = 1'b1;
    #625;
    sclk = 1'b1;
    #625;
    sda_low = 1'b0;
    #1250;
  endtask
  // one bit of 2.5 us
  task automatic i2c_bit(input logic b, output logic r);
    sda_low = ~b;
    #625;
    sclk = 1'b1;
    #625;
    r = pin;
    #625;
    sclk = 1'b0;
    #625;
  endtask
  task automatic i2c_byte(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) i2c_bit(tx[i], rx[i]);
    i2c_bit(last, ack);
  endtask
endmodule

// ---- bench/hsrp_port_tb.sv ----
// self-checking bench for the serial host register port
`timescale 1ns/1ps
module hsrp_port_tb
  import hsrp_pkg::*;
;
  // *****
  // signals
  // *****
  localparam logic [6:0] DEV = {I2C_ADDR_HI_DEF, 2'h2};
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic host_port_select = 1'b0;
  logic flip_r = 1'b0;
  wire logic sclk, cs_n, mosi, sda_low, pin;
  logic host_serial_out, host_serial_out_oe, spi_mode, reg_wr, reg_rd, ack;
  logic [8:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rx;
  logic [15:0] rd;
  logic [16:0] wq [$];
  logic [14:0] rows [4] = '{{7'h00, 8'hA1}, {7'h3C, 8'h5E}, {7'h55, 8'h00}, {7'h7D, 8'hFF}};
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int rd_count = 0;
  function automatic logic [7:0] pat(input logic [8:0] a);
    return a[7:0] ^ {a[8], 7'h2B};
  endfunction
  assign reg_rdata = pat(reg_addr);
  assign pin = host_port_select ? ((host_serial_out_oe ? host_serial_out : 1'b1) & ~sda_low)
                                : (host_serial_out_oe ? host_serial_out : flip_r);
  hsrp_host_model host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .sda_low(sda_low), .pin(pin),
    .i2c(host_port_select));
  hsrp_port uut (
    .clock(clock), .sys_rst(sys_rst), .host_port_select(host_port_select),
    .host_serial_clock(sclk), .host_chip_select_n(cs_n), .host_serial_in(mosi),
    .host_serial_out_in(pin), .host_serial_out(host_serial_out), .host_serial_out_oe(host_serial_out_oe),
    .spi_mode(spi_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );
  always #10 clock = ~clock;
  always @(posedge clock) begin
    flip_r <= ~flip_r;
    cyc <= cyc + 1;
    if (reg_wr === 1'b1) wq.push_back({reg_addr, reg_wdata});
    if (reg_rd === 1'b1) rd_count++;
    if (cyc == 60000) begin
      err_count++;
      end_of_test();
    end
  end
  // *****
  // tasks
  // *****
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t bit got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [16:0] got, input logic [16:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t value got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic exp_wr(input logic [8:0] a, input logic [7:0] d);
    logic [16:0] g;
    g = (wq.size() > 0) ? wq.pop_front() : 17'h1FFFF;
    chk_val(g, {a, d});
  endtask
  task automatic spi_frame(input logic [7:0] cmd, input logic [7:0] dum, input logic [7:0] d0,
                           output logic [15:0] r);
    host.spi_begin();
    host.spi_byte(cmd, rx);
    host.spi_byte(dum, rx);
    host.spi_byte(d0, r[15:8]);
    host.spi_byte(d0 + 8'h01, r[7:0]);
    host.spi_end();
    repeat (8) @(negedge clock);
  endtask
  task automatic i2c_wr(input logic [7:0] rb, input logic [7:0] d0, input logic [7:0] d1);
    host.i2c_start();
    host.i2c_byte({DEV, 1'b0}, 1'b1, rx, ack);
    chk_bit(ack, 1'b0);
    host.i2c_byte(rb, 1'b1, rx, ack);
    chk_bit(ack, 1'b0);
    host.i2c_byte(d0, 1'b1, rx, ack);
    host.i2c_byte(d1, 1'b1, rx, ack);
    chk_bit(ack, 1'b0);
    host.i2c_stop();
  endtask
  task automatic i2c_rd(input logic with_reg, input logic [7:0] rb, output logic [15:0] r);
    host.i2c_start();
    if (with_reg) begin
      host.i2c_byte({DEV, 1'b0}, 1'b1, rx, ack);
      host.i2c_byte(rb, 1'b1, rx, ack);
      host.i2c_start();
    end
    host.i2c_byte({DEV, 1'b1}, 1'b1, rx, ack);
    chk_bit(ack, 1'b0);
    host.i2c_byte(8'hFF, 1'b0, r[15:8], ack);
    host.i2c_byte(8'hFF, 1'b1, r[7:0], ack);
    host.i2c_stop();
  endtask
  task automatic end_of_test();
    if (err_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // *****
  // main sequence
  // *****
  initial begin
    repeat (16) @(negedge clock);
    sys_rst = 1'b0;
    repeat (4) @(negedge clock);
    chk_bit(spi_mode, 1'b1);
    for (int i = 0; i < 4; i++) begin
      spi_frame({1'b0, rows[i][14:8]}, 8'h00, rows[i][7:0], rd);
      exp_wr({2'h0, rows[i][14:8]}, rows[i][7:0]);
      exp_wr({2'h0, rows[i][14:8] + 7'h01}, rows[i][7:0] + 8'h01);
      spi_frame({1'b1, rows[i][14:8]}, 8'hFF, 8'h00, rd);
      chk_val({1'b0, rd}, {1'b0, pat({2'h0, rows[i][14:8]}), pat({2'h0, rows[i][14:8] + 7'h01})});
      chk_val(17'(wq.size()), 17'h0);
    end
    chk_bit(host_serial_out_oe, 1'b0);
    host.spi_noise();
    repeat (8) @(negedge clock);
    chk_val(17'(wq.size()), 17'h0);
    spi_frame({1'b0, PAGE_SEL_ADDR}, 8'h5A, 8'h02, rd);
    exp_wr({2'h2, 7'h00}, 8'h03);
    chk_val(17'(wq.size()), 17'h0);
    spi_frame({1'b1, PAGE_SEL_ADDR}, 8'h00, 8'h00, rd);
    chk_val({1'b0, rd}, {9'h002, pat({2'h2, 7'h00})});
    @(negedge clock);
    sys_rst = 1'b1;
    host_port_select = 1'b1;
    host.i2c_idle(2'h2);
    repeat (16) @(negedge clock);
    sys_rst = 1'b0;
    repeat (4) @(negedge clock);
    chk_bit(spi_mode, 1'b0);
    rd_count = 0;
    i2c_wr({1'b1, 7'h20}, 8'h11, 8'h22);
    exp_wr({2'h0, 7'h20}, 8'h11);
    exp_wr({2'h0, 7'h21}, 8'h22);
    i2c_wr({1'b0, 7'h30}, 8'h33, 8'h44);
    exp_wr({2'h0, 7'h30}, 8'h33);
    exp_wr({2'h0, 7'h30}, 8'h44);
    i2c_rd(1'b0, 8'h00, rd);
    chk_val({1'b0, rd}, {1'b0, pat(9'h030), pat(9'h030)});
    i2c_rd(1'b1, {1'b1, 7'h40}, rd);
    chk_val({1'b0, rd}, {1'b0, pat(9'h040), pat(9'h041)});
    i2c_rd(1'b1, {1'b0, 7'h50}, rd);
    chk_val({1'b0, rd}, {1'b0, pat(9'h050), pat(9'h050)});
    for (int i = 0; i < 2; i++) begin
      host.i2c_start();
      host.i2c_byte({DEV ^ ((i == 0) ? 7'h01 : 7'h40), 1'b0}, 1'b1, rx, ack);
      chk_bit(ack, 1'b1);
      host.i2c_stop();
    end
    chk_val(17'(wq.size()), 17'h0);
    chk_val(17'(rd_count), 17'h6);
    chk_bit(host_serial_out, 1'b0);
    end_of_test();
  end
endmodule
